// file: design/pzr_map.vh
// Constants for the position zero reference block.
// Assumes 32-bit AXI4-Lite register access, byte addresses.
`ifndef PZR_MAP_VH
`define PZR_MAP_VH
// Register byte offsets
`define PZR_CTRL        6'h00
`define PZR_HOME_POS_IN 6'h04
`define PZR_HOME_OFS_IN 6'h08
`define PZR_ABS_IN      6'h0c
`define PZR_ADAPT_NUM   6'h10
`define PZR_ADAPT_DEN   6'h14
`define PZR_EFF_HOME    6'h18
`define PZR_EFF_OFS     6'h1c
`define PZR_ACT_POS     6'h20
`define PZR_SET_POS     6'h24
`define PZR_STATUS      6'h28
`define PZR_RAW_POS     6'h2c
`define PZR_SPEED       6'h30
`define PZR_QSP_TIME    6'h34
// Control fields
`define PZR_C_FB_LSB    0
`define PZR_C_PSM_LSB   4
`define PZR_C_SET_POL   9
`define PZR_C_ACT_POL   10
`define PZR_C_ABS_SET   11
`define PZR_C_HOMING    12
`define PZR_C_SETHOME   13
`define PZR_C_MANUAL    14
`define PZR_C_PROG      15
`define PZR_C_FLTCLR    16
`define PZR_C_MAN_OUT   17
`define PZR_C_NOREV     18
`define PZR_C_SW_INV    19
// Status fields
`define PZR_S_REF_OK    0
`define PZR_S_FAULT     1
`define PZR_S_QSP       2
`define PZR_S_REFUSE    3
`define PZR_S_LIMP      4
`define PZR_S_LIMN      5
`define PZR_S_ABSFB     6
// Values
`define PZR_FB_ABS_MT   4'h4
`define PZR_PSM_SETPOS  5'h05
`define PZR_PSM_HOMEACC 5'h10
`define PZR_PSM_HOMING  5'h03
`define PZR_MT_MASK     32'h0fffffff
`define PZR_RES_SHIFT   16
`define PZR_RESP_OKAY   2'h0
`define PZR_RESP_SLVERR 2'h2
`define PZR_QSP_DEFAULT 32'h00000064
`endif

// file: design/pzr_position_zero_reference.v
// Position zero reference logic with AXI4-Lite register slave.
// Assumes one 100 MHz clock, synchronous active-low reset, switch pins
// asynchronous to aclk.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pzr_map.vh"
// Function
// - Machine zero lies reference position below home position.
// - Reference position taken only during homing or set-home function.
// - Reference offset shifts real zero, positive offset moves it positive.
// - Offset change applies at once to setpoint and actual position.
// - Absolute feedback uses encoder zero as home position.
// - Negative effective home moves machine zero positive into range.
// - At power-on load effective home and offset from inputs.
// - In operation home input copied only during homing or when program mode is 16.
// - Set-home sets effective home to negated actual, offset to input.
// - Absolute feedback refuses program homing, manual homing, set-position.
// - Multi-turn count wraps at 65536 times 4096 increments.
// - Feedback selection value 4 selects absolute multi-turn feedback.
// - Overflow raises no flag and moves across it stay allowed.
// - Absolute value input accepted only while accept bit is one.
// - Accept high sets home-position-known status automatically.
// - Bus value rescaled to 65536 per revolution by numerator/denominator.
// - Setpoint and actual polarity both applied to absolute input.
// - Actual position equals absolute plus home minus offset.
// - Accept high at initialisation loads effective home from input.
// - Travel switches active low by default, open reads active.
// - Fault when switch active and speed, manual or homing condition.
// - Fault decelerates by quick-stop ramp with adjustable time.
module pzr_position_zero_reference (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Encoder and switches
  input  wire [31:0] encoder_count,
  input  wire        travel_switch_positive_n,
  input  wire        travel_switch_negative_n,
  // Drive outputs
  output reg         fault_quick_stop,
  output reg  [31:0] quick_stop_ramp_time
);

  //--------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------
  reg [31:0] ctrl_r;
  reg [31:0] home_in_r;
  reg [31:0] ofs_in_r;
  reg [31:0] abs_in_r;
  reg [15:0] num_r;
  reg [15:0] den_r;
  reg [31:0] eff_home_r;
  reg [31:0] eff_ofs_r;
  reg [31:0] setpos_r;
  reg [31:0] speed_r;
  reg [31:0] abs_lat_r;
  reg        ref_ok_r;
  reg        fault_r;
  reg        refuse_r;
  reg        init_r;
  reg [2:0]  limp_sync_r;
  reg [2:0]  limn_sync_r;
  reg        limp_r;
  reg        limn_r;
  reg [31:0] act_pos_r;
  // Edge detect for the set-home request
  reg        set_home_d_r;

  //--------------------------------------------------------------
  // Decoded controls
  //--------------------------------------------------------------
  wire [3:0] feedback_select  = ctrl_r[`PZR_C_FB_LSB+3:`PZR_C_FB_LSB];
  wire [4:0] program_set_mode = ctrl_r[`PZR_C_PSM_LSB+4:`PZR_C_PSM_LSB];
  wire setpoint_polarity      = ctrl_r[`PZR_C_SET_POL];
  wire actual_value_polarity  = ctrl_r[`PZR_C_ACT_POL];
  wire absolute_accept        = ctrl_r[`PZR_C_ABS_SET];
  wire homing_run             = ctrl_r[`PZR_C_HOMING];
  wire set_home_req           = ctrl_r[`PZR_C_SETHOME];
  wire manual_mode            = ctrl_r[`PZR_C_MANUAL];
  wire prog_mode              = ctrl_r[`PZR_C_PROG];
  wire manual_out             = ctrl_r[`PZR_C_MAN_OUT];
  wire homing_norev           = ctrl_r[`PZR_C_NOREV];
  wire switch_invert          = ctrl_r[`PZR_C_SW_INV];

  // Absolute multi-turn feedback chosen by value 4
  wire abs_fb = (feedback_select == `PZR_FB_ABS_MT);

  // Homing and set-position requests refused with absolute feedback
  wire homing_req  = homing_run &&
                     (manual_mode || program_set_mode == `PZR_PSM_HOMING);
  wire setpos_req  = prog_mode && program_set_mode == `PZR_PSM_SETPOS;
  // Refused requests leave the effective values untouched
  wire refused     = abs_fb && (homing_req || setpos_req);
  wire homing_ok   = homing_run && !refused;
  // Set-home acts once per rising request; held high it would feed
  // the actual position back into the home value every cycle
  wire set_home_go = set_home_req && !set_home_d_r && !refused;

  //--------------------------------------------------------------
  // Absolute value path
  //--------------------------------------------------------------
  // Rescale to 65536 incr/rev with integer ratio
  // Zero denominator counts as denominator one, no divide by zero
  wire signed [47:0] scaled_w = $signed(abs_lat_r) *
                                $signed({1'b0, num_r});
  wire signed [47:0] den_w    = $signed({32'h0, den_r});
  wire signed [47:0] div_w    = (den_r == 16'h0) ? scaled_w :
                                scaled_w / den_w;
  // Both polarities act on the read value
  // Two inversions cancel, so only one set bit flips the sign
  wire pol_flip = setpoint_polarity ^ actual_value_polarity;
  wire [31:0] bus_abs = pol_flip ? (32'h0 - div_w[31:0]) : div_w[31:0];
  // Encoder zero is home; count wraps silently
  // No flag on wrap; keep encoder zero outside the travel range
  // so the wrap point is never crossed in normal work
  wire [31:0] mt_abs  = encoder_count & `PZR_MT_MASK;
  // Other feedback selections take the rescaled bus value
  wire [31:0] abs_src = abs_fb ? mt_abs : bus_abs;
  // Actual = abs + home - offset, signed increments
  // Registered below, so one cycle behind its inputs
  wire [31:0] act_nxt = abs_src + eff_home_r - eff_ofs_r;

  //--------------------------------------------------------------
  // AXI4-Lite handshake
  //--------------------------------------------------------------
  // Address and data are taken together only; a lone address
  // waits for its data. One write answer at a time, one read
  // answer at a time.
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  wire [3:0] wsel = s_axi_awaddr[5:2];

  // Byte-lane merge
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  st;
    begin
      merge = {st[3] ? dat[31:24] : old[31:24],
               st[2] ? dat[23:16] : old[23:16],
               st[1] ? dat[15:8]  : old[15:8],
               st[0] ? dat[7:0]   : old[7:0]};
    end
  endfunction

  // Read-only, unmapped or misaligned offsets: SLVERR, no store
  wire wr_ok = wr_go && s_axi_awaddr[1:0] == 2'h0 &&
               s_axi_awaddr <= `PZR_QSP_TIME && (
               s_axi_awaddr <= `PZR_ADAPT_DEN ||
               s_axi_awaddr == `PZR_SPEED ||
               s_axi_awaddr == `PZR_QSP_TIME);
  wire wr_ofs  = wr_ok && s_axi_awaddr == `PZR_HOME_OFS_IN;
  wire [31:0] ofs_wdata = merge(ofs_in_r, s_axi_wdata, s_axi_wstrb);
  // Narrow ratio registers keep only the low half-word
  wire [31:0] num_wdata = merge({16'h0, num_r}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] den_wdata = merge({16'h0, den_r}, s_axi_wdata, s_axi_wstrb);

  // Write side: registers and response
  // Response raised one cycle after the write is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r               <= 32'h00000000;
      home_in_r            <= 32'h00000000;
      ofs_in_r             <= 32'h00000000;
      abs_in_r             <= 32'h00000000;
      num_r                <= 16'h0001;
      den_r                <= 16'h0001;
      speed_r              <= 32'h00000000;
      quick_stop_ramp_time <= `PZR_QSP_DEFAULT;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `PZR_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `PZR_RESP_OKAY : `PZR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ok) begin
        case (wsel)
          4'h0: ctrl_r   <= merge(ctrl_r, s_axi_wdata, s_axi_wstrb);
          4'h1: home_in_r <= merge(home_in_r, s_axi_wdata, s_axi_wstrb);
          4'h2: ofs_in_r <= ofs_wdata;
          4'h3: abs_in_r <= merge(abs_in_r, s_axi_wdata, s_axi_wstrb);
          4'h4: num_r    <= num_wdata[15:0];
          4'h5: den_r    <= den_wdata[15:0];
          4'hc: speed_r  <= merge(speed_r, s_axi_wdata, s_axi_wstrb);
          4'hd: quick_stop_ramp_time <= merge(quick_stop_ramp_time,
                                              s_axi_wdata, s_axi_wstrb);
          default: ;
        endcase
      end
      // Fault clear bit is self-clearing; it stands one cycle so
      // the clear reaches the fault flag before it drops
      if (ctrl_r[`PZR_C_FLTCLR] && !(wr_ok && wsel == 4'h0))
        ctrl_r[`PZR_C_FLTCLR] <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // Reference handling
  //--------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      eff_home_r <= 32'h00000000;
      eff_ofs_r  <= 32'h00000000;
      init_r     <= 1'b1;
      abs_lat_r  <= 32'h00000000;
      ref_ok_r   <= 1'b0;
      refuse_r   <= 1'b0;
      act_pos_r  <= 32'h00000000;
      setpos_r   <= 32'h00000000;
      set_home_d_r <= 1'b0;
    end else begin
      // Power-on load runs only in the first cycle after reset
      init_r   <= 1'b0;
      refuse_r <= refused;
      set_home_d_r <= set_home_req;
      // Bus value taken only while accept is high
      if (absolute_accept)
        abs_lat_r <= abs_in_r;
      if (init_r) begin
        // Power-on load of effective values
        eff_home_r <= home_in_r;
        eff_ofs_r  <= ofs_in_r;
      end else begin
        // Home copy via homing, set-home or mode 16 only; homing and
        // mode 16 copy again each cycle while they are held
        if (set_home_go)
          eff_home_r <= 32'h0 - act_pos_r;
        else if (homing_ok ||
                 (prog_mode && program_set_mode == `PZR_PSM_HOMEACC))
          eff_home_r <= home_in_r;
        // Offset change takes effect at once
        if (wr_ofs)
          eff_ofs_r <= ofs_wdata;
        else if (set_home_go)
          eff_ofs_r <= ofs_in_r;
      end
      // Actual and setpoint follow current real zero
      act_pos_r <= act_nxt;
      // Setpoint moves by old minus new offset, so the target in
      // machine terms stays where it was
      if (wr_ofs)
        setpos_r <= setpos_r + eff_ofs_r - ofs_wdata;
      else if (homing_ok || set_home_go)
        setpos_r <= act_nxt;
      // Reference known status
      // Start of homing drops it; accept or absolute feedback hold it
      if (absolute_accept || abs_fb)
        ref_ok_r <= 1'b1;
      else if (homing_run)
        ref_ok_r <= 1'b0;
      else if (set_home_go)
        ref_ok_r <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // Travel switch supervision
  //--------------------------------------------------------------
  // Accepted level resets to active, but stages two and three reset to zero,
  // so the first edge after reset accepts the inactive level; an open pin reads active too
  wire limp_act = limp_r ^ switch_invert;
  wire limn_act = limn_r ^ switch_invert;
  // Either end switch counts; direction is not checked here
  wire lim_any  = limp_act || limn_act;
  wire fault_cause = lim_any &&
                     ((prog_mode && speed_r != 32'h0) ||
                      (manual_mode && manual_out) ||
                      (homing_run && homing_norev));

  always @(posedge aclk) begin
    if (!aresetn) begin
      limp_sync_r      <= 3'h0;
      limn_sync_r      <= 3'h0;
      limp_r           <= 1'b1;
      limn_r           <= 1'b1;
      fault_r          <= 1'b0;
      fault_quick_stop <= 1'b0;
    end else begin
      // Stage one may be metastable; only stages two and three
      // are compared before a new level is accepted
      limp_sync_r <= {limp_sync_r[1:0], !travel_switch_positive_n};
      limn_sync_r <= {limn_sync_r[1:0], !travel_switch_negative_n};
      if (limp_sync_r[2] == limp_sync_r[1])
        limp_r <= limp_sync_r[2];
      if (limn_sync_r[2] == limn_sync_r[1])
        limn_r <= limn_sync_r[2];
      // Set wins over clear
      if (fault_cause)
        fault_r <= 1'b1;
      else if (ctrl_r[`PZR_C_FLTCLR])
        fault_r <= 1'b0;
      // Output is set at the same edge as fault_r, not one cycle after it
      fault_quick_stop <= fault_cause || fault_r;
    end
  end

  //--------------------------------------------------------------
  // Read side
  //--------------------------------------------------------------
  // Register read multiplexer, decoded on the full offset
  reg [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr)
      `PZR_CTRL:        rd_mux = ctrl_r;
      `PZR_HOME_POS_IN: rd_mux = home_in_r;
      `PZR_HOME_OFS_IN: rd_mux = ofs_in_r;
      `PZR_ABS_IN:      rd_mux = abs_in_r;
      `PZR_ADAPT_NUM:   rd_mux = {16'h0, num_r};
      `PZR_ADAPT_DEN:   rd_mux = {16'h0, den_r};
      `PZR_EFF_HOME:    rd_mux = eff_home_r;
      `PZR_EFF_OFS:     rd_mux = eff_ofs_r;
      `PZR_ACT_POS:     rd_mux = act_pos_r;
      `PZR_SET_POS:     rd_mux = setpos_r;
      // Status word, bit 6 down to bit 0
      `PZR_STATUS:      rd_mux = {25'h0, abs_fb, limn_act, limp_act,
                                  refuse_r, fault_quick_stop, fault_r,
                                  ref_ok_r};
      `PZR_RAW_POS:     rd_mux = abs_src;
      `PZR_SPEED:       rd_mux = speed_r;
      `PZR_QSP_TIME:    rd_mux = quick_stop_ramp_time;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Unmapped offsets read as zero with SLVERR
  wire rd_map = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `PZR_QSP_TIME;

  // Read response, one cycle after address
  // Data and response stand until rready is seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PZR_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_map ? rd_mux : 32'h00000000;
      s_axi_rresp  <= rd_map ? `PZR_RESP_OKAY : `PZR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: dv/pzr_checker_sva.sv
// Checker on the position zero reference top-level ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module pzr_checker_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Drive outputs
  input wire logic        fault_quick_stop,
  input wire logic [31:0] quick_stop_ramp_time
);
  // ------------------
  // Assertions
  // ------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Write taken whole at this edge
  wire aw_take;
  assign aw_take = s_axi_awvalid && s_axi_awready &&
                   s_axi_wvalid && s_axi_wready;
  a_write_answer: assert property (aw_take |=> s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_write_ready: assert property (s_axi_awready |->
    s_axi_wready && !s_axi_bvalid) else $error("write ready misplaced");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_fault_sticky: assert property ($fell(fault_quick_stop) |->
    $past(aw_take) || $past(aw_take, 2) || $past(aw_take, 3))
    else $error("fault cleared without write");
  a_ramp_reset: assert property ($rose(aresetn) |->
    quick_stop_ramp_time == 32'h00000064) else $error("ramp reset value");
  a_ramp_by_write: assert property (!$stable(quick_stop_ramp_time) |->
    $past(aw_take) || $past(aw_take, 2)) else $error("ramp changed alone");
  // Main scenarios
  c_write: cover property (aw_take);
  c_fault_on: cover property ($rose(fault_quick_stop));
  c_fault_off: cover property ($fell(fault_quick_stop));
endmodule
bind pzr_position_zero_reference pzr_checker_sva chk_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .fault_quick_stop, .quick_stop_ramp_time
);
`default_nettype wire

// file: dv/pzr_far_side.sv
// Far side model: multi-turn encoder and end-of-travel switches.
// Assumes the bench sets encoder value and switch contact states.
`timescale 1ns/1ns
`default_nettype none
module pzr_far_side (
  // Clock
  input  wire logic        aclk,
  // Bench commands
  input  wire logic [31:0] enc_val,
  input  wire logic        lim_p_on,
  input  wire logic        lim_n_on,
  // Drive pins
  output var  logic [31:0] encoder_count,
  output wire logic        travel_switch_positive_n,
  output wire logic        travel_switch_negative_n
);
  // Encoder count moves on the drive clock
  initial encoder_count = 32'h0;
  always @(posedge aclk) begin
    encoder_count <= enc_val;
  end
  // A hit switch opens the loop, so the pin reads low
  assign travel_switch_positive_n = !lim_p_on;
  assign travel_switch_negative_n = !lim_n_on;
endmodule
`default_nettype wire

// file: dv/pzr_position_zero_reference_bench.sv
// Bench for the position zero reference block.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "pzr_map.vh"
module pzr_position_zero_reference_bench;
  // Stimulus and observed signals
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, enc_val = 32'h0, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, lim_p_on = 1'h0, lim_n_on = 1'h0;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, encoder_count, quick_stop_ramp_time;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, fault_quick_stop;
  wire         travel_switch_positive_n, travel_switch_negative_n;
  int          err_count = 0, n_compared = 0, cycles = 0, i;
  logic [31:0] refuse_tbl [3] = '{32'h9034, 32'h8054, 32'h5004};
  // Clock and hang guard
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  // Design and far side
  pzr_position_zero_reference uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .encoder_count, .fault_quick_stop,
    .travel_switch_positive_n, .travel_switch_negative_n,
    .quick_stop_ramp_time
  );
  pzr_far_side far (
    .aclk, .enc_val, .lim_p_on, .lim_n_on, .encoder_count,
    .travel_switch_positive_n, .travel_switch_negative_n
  );
  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // Bus write, address and data offered together
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic fa, fw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fa = 1'h0;
    fw = 1'h0;
    while (!(fa && fw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        fa = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        fw = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // Bus read into v
  task rd(input logic [5:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    rd(a, 2'h0);
    chk(nm, e, v);
  endtask
  // Bounded wait for the quick-stop level
  task wait_fault(input logic e);
    for (i = 0; i < 12 && fault_quick_stop !== e; i++) @(posedge aclk);
    chk("fault", {31'h0, e}, {31'h0, fault_quick_stop});
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rdc("ramp", `PZR_QSP_TIME, 32'h64);
    rdc("home", `PZR_EFF_HOME, 32'h0);
    rdc("offset", `PZR_EFF_OFS, 32'h0);
    wr(`PZR_HOME_POS_IN, 32'h100, 2'h0);
    enc_val <= 32'h10000010;
    wr(`PZR_CTRL, 32'h4, 2'h0);
    rdc("home", `PZR_EFF_HOME, 32'h0);
    rdc("actual", `PZR_ACT_POS, 32'h10);
    wr(`PZR_CTRL, 32'h8104, 2'h0);
    rdc("home", `PZR_EFF_HOME, 32'h100);
    rdc("actual", `PZR_ACT_POS, 32'h110);
    wr(`PZR_CTRL, 32'h4, 2'h0);
    wr(`PZR_HOME_OFS_IN, 32'h20, 2'h0);
    rdc("offset", `PZR_EFF_OFS, 32'h20);
    rdc("actual", `PZR_ACT_POS, 32'hf0);
    for (int k = 0; k < 3; k++) begin
      wr(`PZR_CTRL, refuse_tbl[k], 2'h0);
      rd(`PZR_STATUS, 2'h0);
      chk("refused", 32'h1, {31'h0, v[`PZR_S_REFUSE]});
      chk("absfb", 32'h1, {31'h0, v[`PZR_S_ABSFB]});
    end
    wr(`PZR_ADAPT_NUM, 32'h6, 2'h0);
    wr(`PZR_ADAPT_DEN, 32'h2, 2'h0);
    wr(`PZR_ABS_IN, 32'h10, 2'h0);
    wr(`PZR_CTRL, 32'h800, 2'h0);
    rdc("actual", `PZR_ACT_POS, 32'h110);
    rd(`PZR_STATUS, 2'h0);
    chk("ref ok", 32'h1, {31'h0, v[`PZR_S_REF_OK]});
    wr(`PZR_CTRL, 32'ha00, 2'h0);
    rdc("actual", `PZR_ACT_POS, 32'hb0);
    wr(`PZR_CTRL, 32'he00, 2'h0);
    rdc("actual", `PZR_ACT_POS, 32'h110);
    wr(`PZR_CTRL, 32'h0, 2'h0);
    wr(`PZR_ABS_IN, 32'h40, 2'h0);
    rdc("actual", `PZR_ACT_POS, 32'h110);
    wr(`PZR_SPEED, 32'h0, 2'h0);
    wr(`PZR_CTRL, 32'h8000, 2'h0);
    lim_n_on <= 1'h1;
    repeat (10) @(posedge aclk);
    wait_fault(1'h0);
    rd(`PZR_STATUS, 2'h0);
    chk("lim neg", 32'h1, {31'h0, v[`PZR_S_LIMN]});
    lim_n_on <= 1'h0;
    repeat (10) @(posedge aclk);
    wr(`PZR_SPEED, 32'h10, 2'h0);
    lim_p_on <= 1'h1;
    wait_fault(1'h1);
    lim_p_on <= 1'h0;
    repeat (10) @(posedge aclk);
    wait_fault(1'h1);
    wr(`PZR_CTRL, 32'h18000, 2'h0);
    wait_fault(1'h0);
    wr(6'h38, 32'h1, 2'h2);
    wr(`PZR_EFF_HOME, 32'h1, 2'h2);
    rd(6'h3c, 2'h2);
    chk("unmapped", 32'h0, v);
    rdc("home", `PZR_EFF_HOME, 32'h100);
    wr(`PZR_CTRL, 32'h4, 2'h0);
    wr(`PZR_CTRL, 32'h2004, 2'h0);
    rdc("home", `PZR_EFF_HOME, 32'hffffff10);
    rdc("offset", `PZR_EFF_OFS, 32'h20);
    rdc("actual", `PZR_ACT_POS, 32'hffffff00);
    wr(`PZR_QSP_TIME, 32'h1f4, 2'h0);
    chk("ramp out", 32'h1f4, quick_stop_ramp_time);
    report_and_stop;
  end
endmodule
`default_nettype wire
